// *** ssr_consts.svh ***
// Constants for the sync status readback bank
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// Notes on behaviour
// - Register 0 holds four-bit revision, upper unused
// - Polarity bit 0 means mostly low input
// - Register 1 holds six sync polarity bits
// - Register 2 holds eight activity bits, one active
// - Register 3 bit 6 flags spurious pulses
// - Register 3 bit 5 flags tri-level sync
// - Register 3 bit 4 shows field output activity
// - Register 3 bit 3 mirrors new-input output
// - Register 3 bit 2 shows separated vertical activity
// - Register 3 read-only; bits 1,0 test
// - Two-bit select picks one of four registers
// - Standby keeps new-input output driven only
`define SSR_READBACK_SELECT_REG_OFFSET 8'h1f
`define SSR_SEL_REVISION    2'h0
`define SSR_SEL_POLARITY    2'h1
`define SSR_SEL_PRESENCE    2'h2
`define SSR_SEL_SEPARATOR   2'h3
`define SSR_SEL_RESET       2'h0
`define SSR_UNUSED_FILL     1'h0
`define SSR_STATUS_RESET    8'h00
`define SSR_BIT_SPURIOUS    6
`define SSR_BIT_TRILEVEL    5
`define SSR_BIT_FIELD       4
`define SSR_BIT_NEWINPUT    3
`define SSR_BIT_SEPVERT     2
`define SSR_BIT_TESTB       1
`define SSR_BIT_TESTA       0
`define SSR_REVISION_DEFAULT 4'h0
`endif

// *** ssr_pkg.sv ***
// Types for the sync status readback bank
`default_nettype none
package ssr_pkg;
  typedef logic [1:0] ssr_sel_t;
  typedef logic [7:0] ssr_byte_t;
endpackage
`default_nettype wire

// *** ssr_sync.sv ***
// Two-stage synchroniser for a bundle of status levels
`timescale 1ns/1ps
`default_nettype none
module ssr_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** ssr_readback.sv ***
// Read-only sync status bank with register select and standby gating
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"
module ssr_readback #(
  parameter logic [3:0] REVISION = `SSR_REVISION_DEFAULT // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       sel_wr,
  input  wire logic [1:0] sel_wdata,
  input  wire logic       standby,
  input  wire logic [5:0] polarity_in,
  input  wire logic [7:0] presence_in,
  input  wire logic       spurious_in,
  input  wire logic       trilevel_in,
  input  wire logic       field_in,
  input  wire logic       new_input_in,
  input  wire logic       sepvert_in,
  input  wire logic [1:0] test_in,
  output logic [7:0]      read_data,
  output logic            read_oe_n,
  output logic            new_input_indicator,
  output logic            new_input_oe_n
);
  ssr_pkg::ssr_sel_t  readback_select_reg;
  ssr_pkg::ssr_byte_t sync_q;
  ssr_pkg::ssr_byte_t pres_q;
  logic [5:0]         sep_q;
  ssr_pkg::ssr_byte_t next_read_data;

  // Select written by host
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readback_select_reg <= `SSR_SEL_RESET;
    end else if (ce && sel_wr) begin
      readback_select_reg <= sel_wdata;
    end
  end

  // Resynchronise all status except the test bits so each byte is coherent
  // Two stages plus the output flop put three clocks between a pin
  // and the byte; latency is traded for never mixing old and new bits
  ssr_sync #(.W(8)) u_pol (
    .clk (clk),
    .nrst(nrst),
    .ce  (ce),
    .d   ({2'h0, polarity_in}),
    .q   (sync_q)
  );
  ssr_sync #(.W(8)) u_pres (
    .clk (clk),
    .nrst(nrst),
    .ce  (ce),
    .d   (presence_in),
    .q   (pres_q)
  );
  ssr_sync #(.W(6)) u_sep (
    .clk (clk),
    .nrst(nrst),
    .ce  (ce),
    .d   ({spurious_in, trilevel_in, field_in, new_input_in, sepvert_in,
           standby}),
    .q   (sep_q)
  );

  // Read mux; purely a view, so reads never disturb status
  always_comb begin
    next_read_data = `SSR_STATUS_RESET;
    case (readback_select_reg)
      `SSR_SEL_REVISION: next_read_data = {4'h0, REVISION};
      `SSR_SEL_POLARITY: next_read_data = {2'h0, sync_q[5:0]};
      `SSR_SEL_PRESENCE: next_read_data = pres_q;
      `SSR_SEL_SEPARATOR: begin
        next_read_data[`SSR_BIT_SPURIOUS] = sep_q[5];
        next_read_data[`SSR_BIT_TRILEVEL] = sep_q[4];
        next_read_data[`SSR_BIT_FIELD]    = sep_q[3];
        next_read_data[`SSR_BIT_NEWINPUT] = sep_q[2];
        next_read_data[`SSR_BIT_SEPVERT]  = sep_q[1];
        next_read_data[`SSR_BIT_TESTB]    = test_in[1];
        next_read_data[`SSR_BIT_TESTA]    = test_in[0];
      end
      default: next_read_data = `SSR_STATUS_RESET;
    endcase
  end

  // Registered read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_data <= `SSR_STATUS_RESET;
    end else if (ce) begin
      read_data <= next_read_data;
    end
  end

  // Indicator is the same synchronised level the status byte shows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      new_input_indicator <= 1'h0;
    end else if (ce) begin
      new_input_indicator <= sep_q[2];
    end
  end

  // Standby floats data but keeps the indicator driven
  assign read_oe_n      = sep_q[0];
  assign new_input_oe_n = 1'h0;

  // The select loads only on a strobe taken with the enable high
  property p_sel_follows;
    @(posedge clk) disable iff (!nrst)
      (ce && sel_wr) |=> (readback_select_reg == $past(sel_wdata));
  endproperty
  a_sel_follows: assert property (p_sel_follows)
    else $error("Select did not load");

  property p_rev;
    @(posedge clk) disable iff (!nrst)
      (ce && readback_select_reg == `SSR_SEL_REVISION)
        |=> (read_data == {4'h0, REVISION});
  endproperty
  a_rev: assert property (p_rev)
    else $error("Revision read wrong");

  property p_pol_top;
    @(posedge clk) disable iff (!nrst)
      (ce && readback_select_reg == `SSR_SEL_POLARITY)
        |=> (read_data[7:6] == 2'h0 && read_data[5:0] == $past(sync_q[5:0]));
  endproperty
  a_pol_top: assert property (p_pol_top)
    else $error("Polarity read wrong");

  property p_pres;
    @(posedge clk) disable iff (!nrst)
      (ce && readback_select_reg == `SSR_SEL_PRESENCE)
        |=> (read_data == $past(pres_q));
  endproperty
  a_pres: assert property (p_pres)
    else $error("Activity read wrong");

  sequence s_sep_sel;
    ce && readback_select_reg == `SSR_SEL_SEPARATOR;
  endsequence
  property p_sep7;
    @(posedge clk) disable iff (!nrst)
      s_sep_sel |=> (read_data[7] == 1'h0 &&
                     read_data[`SSR_BIT_SPURIOUS] == $past(sep_q[5]));
  endproperty
  a_sep7: assert property (p_sep7)
    else $error("Spurious bit wrong");

  property p_tri;
    @(posedge clk) disable iff (!nrst)
      s_sep_sel |=> (read_data[`SSR_BIT_TRILEVEL] == $past(sep_q[4]));
  endproperty
  a_tri: assert property (p_tri)
    else $error("Tri-level bit wrong");

  property p_field;
    @(posedge clk) disable iff (!nrst)
      s_sep_sel |=> (read_data[`SSR_BIT_FIELD] == $past(sep_q[3]));
  endproperty
  a_field: assert property (p_field)
    else $error("Field bit wrong");

  property p_newin;
    @(posedge clk) disable iff (!nrst)
      (s_sep_sel ##1 ce) |-> (read_data[`SSR_BIT_NEWINPUT] ==
                               new_input_indicator);
  endproperty
  a_newin: assert property (p_newin)
    else $error("New-input copy differs from output");

  property p_sepv;
    @(posedge clk) disable iff (!nrst)
      s_sep_sel |=> (read_data[`SSR_BIT_SEPVERT] == $past(sep_q[1]));
  endproperty
  a_sepv: assert property (p_sepv)
    else $error("Separated vertical bit wrong");

  property p_stby;
    @(posedge clk) disable iff (!nrst)
      (ce && standby) [*3] |=> (read_oe_n && !new_input_oe_n);
  endproperty
  a_stby: assert property (p_stby)
    else $error("Standby output enables wrong");

  // Chains of enabled clocks that the status pipeline needs to settle
  sequence s_run2;
    ce [*2];
  endsequence

  sequence s_run3;
    ce [*3];
  endsequence

  sequence s_pol_sel;
    ce && readback_select_reg == `SSR_SEL_POLARITY;
  endsequence

  sequence s_pres_sel;
    ce && readback_select_reg == `SSR_SEL_PRESENCE;
  endsequence

  // Select holds unless a strobe is taken; reads alone never move it
  property p_sel_hold;
    @(posedge clk) disable iff (!nrst)
      !(ce && sel_wr) |=> $stable(readback_select_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("Select moved without a strobe");

  // A low enable freezes the output byte and the indicator
  property p_rd_freeze;
    @(posedge clk) disable iff (!nrst)
      !ce |=> $stable(read_data);
  endproperty
  a_rd_freeze: assert property (p_rd_freeze)
    else $error("Read byte changed while frozen");

  property p_ind_freeze;
    @(posedge clk) disable iff (!nrst)
      !ce |=> $stable(new_input_indicator);
  endproperty
  a_ind_freeze: assert property (p_ind_freeze)
    else $error("Indicator changed while frozen");

  // Test bits pass straight through without resynchronising
  property p_test_bits;
    @(posedge clk) disable iff (!nrst)
      s_sep_sel |=> (read_data[`SSR_BIT_TESTB] == $past(test_in[1]) &&
                     read_data[`SSR_BIT_TESTA] == $past(test_in[0]));
  endproperty
  a_test_bits: assert property (p_test_bits)
    else $error("Test bits wrong");

  // Pin to byte latency: two synchroniser stages plus the output flop
  property p_pol_lat;
    @(posedge clk) disable iff (!nrst)
      (s_run2 ##1 s_pol_sel) |=>
        (read_data[5:0] == $past(polarity_in, 3));
  endproperty
  a_pol_lat: assert property (p_pol_lat)
    else $error("Polarity level not carried through");

  property p_pres_lat;
    @(posedge clk) disable iff (!nrst)
      (s_run2 ##1 s_pres_sel) |=> (read_data == $past(presence_in, 3));
  endproperty
  a_pres_lat: assert property (p_pres_lat)
    else $error("Activity level not carried through");

  property p_sep_lat;
    @(posedge clk) disable iff (!nrst)
      (s_run2 ##1 s_sep_sel) |=>
        (read_data[`SSR_BIT_SPURIOUS] == $past(spurious_in, 3) &&
         read_data[`SSR_BIT_TRILEVEL] == $past(trilevel_in, 3) &&
         read_data[`SSR_BIT_FIELD]    == $past(field_in, 3) &&
         read_data[`SSR_BIT_NEWINPUT] == $past(new_input_in, 3) &&
         read_data[`SSR_BIT_SEPVERT]  == $past(sepvert_in, 3));
  endproperty
  a_sep_lat: assert property (p_sep_lat)
    else $error("Separator levels not carried through");

  // The indicator follows its input by the same three enabled clocks
  property p_ind_lat;
    @(posedge clk) disable iff (!nrst)
      s_run3 |=> (new_input_indicator == $past(new_input_in, 3));
  endproperty
  a_ind_lat: assert property (p_ind_lat)
    else $error("Indicator does not follow its input");

  // Data enable reacts two enabled clocks after standby changes
  property p_oe_lat;
    @(posedge clk) disable iff (!nrst)
      s_run2 |=> (read_oe_n == $past(standby, 2));
  endproperty
  a_oe_lat: assert property (p_oe_lat)
    else $error("Data enable does not follow standby");

  // The indicator stays driven at all times, standby or not
  property p_ind_oe;
    @(posedge clk) disable iff (!nrst)
      standby |-> !new_input_oe_n;
  endproperty
  a_ind_oe: assert property (p_ind_oe)
    else $error("Indicator enable released");

  // A strobe for the revision select shows the field two clocks on
  property p_rev_sel;
    @(posedge clk) disable iff (!nrst)
      ((ce && sel_wr && sel_wdata == `SSR_SEL_REVISION) ##1 ce)
        |=> (read_data == {4'h0, REVISION});
  endproperty
  a_rev_sel: assert property (p_rev_sel)
    else $error("Revision not shown after select");

  // Leaving standby drives the data pins again
  property p_stby_off;
    @(posedge clk) disable iff (!nrst)
      (ce && !standby) [*3] |=> !read_oe_n;
  endproperty
  a_stby_off: assert property (p_stby_off)
    else $error("Data pins left floating");
endmodule
`default_nettype wire

// *** ssr_host.sv ***
// Host model that drives the read-select strobe of the bank
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
  input  wire logic       clk,
  output logic            sel_wr,
  output logic [1:0]      sel_wdata
);
  initial begin
    sel_wr = 1'h0;
    sel_wdata = 2'h0;
  end
  // Strobe one select, then wait out the settling time before reading
  task automatic pick(input logic [1:0] s);
    @(negedge clk);
    sel_wr = 1'h1;
    sel_wdata = s;
    @(negedge clk);
    sel_wr = 1'h0;
    sel_wdata = ~s; // Scrambled so a load without strobe would show
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb_sync_status_readback.sv ***
// Self-checking bench for the sync status readback bank
`timescale 1ns/1ps
`default_nettype none
module tb_sync_status_readback;
  logic       clk, nrst, ce, standby, spur, tril, fld, newin, sepv;
  logic       sel_wr, oe_n, ind, ind_oe_n;
  logic [1:0] sel_wdata, tst;
  logic [5:0] pol;
  logic [7:0] pres, rd;
  int         n_mismatch, num_checks, cyc;
  ssr_host u_host (.clk(clk), .sel_wr(sel_wr), .sel_wdata(sel_wdata));
  ssr_readback #(.REVISION(4'ha)) u_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .sel_wr(sel_wr),
    .sel_wdata(sel_wdata), .standby(standby), .polarity_in(pol),
    .presence_in(pres), .spurious_in(spur), .trilevel_in(tril),
    .field_in(fld), .new_input_in(newin), .sepvert_in(sepv),
    .test_in(tst), .read_data(rd), .read_oe_n(oe_n),
    .new_input_indicator(ind), .new_input_oe_n(ind_oe_n));
  // Free-running clock at 40 MHz
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // Compare one byte and count it
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Tests take under a hundred cycles; far beyond that means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Main sequence of select writes and readbacks
  initial begin
    nrst = 1'h0;
    standby = 1'h0;
    spur = 1'h0;
    tril = 1'h0;
    fld = 1'h0;
    newin = 1'h0;
    sepv = 1'h0;
    ce = 1'h1;
    tst = 2'h0;
    pol = 6'h0;
    pres = 8'h0;
    repeat (12) @(negedge clk);
    nrst = 1'h1;
    u_host.pick(2'h2);
    chk("presence reset", 8'h00, rd);
    u_host.pick(2'h0);
    chk("revision", 8'h0a, rd);
    $display("test revision done");
    for (int i = 0; i < 2; i++) begin
      pol = i ? 6'h15 : 6'h2a;
      pres = i ? 8'h5a : 8'ha5;
      u_host.pick(2'h1);
      chk("polarity", {2'h0, pol}, rd);
      u_host.pick(2'h2);
      chk("presence", pres, rd);
    end
    $display("test polarity and presence done");
    spur = 1'h1;
    tril = 1'h0;
    fld = 1'h1;
    newin = 1'h0;
    sepv = 1'h1;
    tst = 2'h2;
    u_host.pick(2'h3);
    chk("separator a", 8'h56, rd);
    chk("indicator a", 8'h00, {7'h0, ind});
    spur = 1'h0;
    tril = 1'h1;
    fld = 1'h0;
    newin = 1'h1;
    sepv = 1'h0;
    tst = 2'h1;
    repeat (5) @(negedge clk);
    chk("separator b", 8'h29, rd);
    chk("indicator b", 8'h01, {7'h0, ind});
    repeat (3) @(negedge clk);
    chk("reread", 8'h29, rd);
    ce = 1'h0;
    pres = 8'hff;
    u_host.pick(2'h2);
    chk("frozen", 8'h29, rd);
    ce = 1'h1;
    $display("test separator done");
    standby = 1'h1;
    repeat (4) @(negedge clk);
    chk("standby oe", 8'h02, {6'h0, oe_n, ind_oe_n});
    standby = 1'h0;
    repeat (4) @(negedge clk);
    chk("active oe", 8'h00, {6'h0, oe_n, ind_oe_n});
    $display("test standby done");
    nrst = 1'h0;
    @(negedge clk);
    chk("reset data", 8'h00, rd);
    chk("reset indicator", 8'h00, {7'h0, ind});
    nrst = 1'h1;
    repeat (3) @(negedge clk);
    chk("revision after reset", 8'h0a, rd);
    $display("test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
